// file: design/pss_sequencer.sv
/*
 Program sequencer: phase generator, program counter, return stack control.
 Assumes the core reports ctl_i during phase T4 of the executing instruction,
 and that the interrupt request line is a level from outside this clock.
*/
//
// Contract
// - four phases make one instruction cycle
// - PC advances and fetches at phase one
// - phases two to four decode and execute
// - fetch overlaps previous instruction's execution
// - jump or call takes two cycles
// - PC increments after ordinary instructions
// - branches load destination into PC
// - taken skip discards prefetch, dummy cycle
// - low PC byte accessible, page-local jump
// - low byte write inserts dummy prefetch
// - stack hidden from software entirely; status register still shows its full flag
// - call and interrupt acknowledge push PC
// - returns pop stack into PC
// - reset points stack at top level
// - full stack holds interrupt until return
// - call on full stack overwrites oldest
// - six return address levels
// - reset starts execution at zero
// - PC spans 2K words
`timescale 1ns/1ns
`default_nettype none
module pss_sequencer
#(
    parameter int LEVELS = pss_pkg::STK_LEVELS
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire pss_pkg::pss_ctl_t ctl_i,
    input wire logic irq_i,
    input wire logic irq_en_i,
    input wire pss_pkg::pss_reg_req_t reg_i,
    output logic [7:0] reg_rdata_o,
    output logic [pss_pkg::PC_W-1:0] pm_addr_o,
    output logic pm_fetch_o,
    output logic [3:0] phase_o,
    output logic exec_valid_o,
    output logic int_ack_o,
    output logic stack_full_o
);
    import pss_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
        pc_inc = pc + 11'h001; // wraps inside the 2K space
    endfunction

    function automatic logic [STK_IDX_W-1:0] idx_step(
        input logic [STK_IDX_W-1:0] idx, input logic up);
        idx_step = up ? ((idx == STK_IDX_W'(LEVELS - 1)) ? '0 : idx + 3'h1)
            : ((idx == '0) ? STK_IDX_W'(LEVELS - 1) : idx - 3'h1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    pss_phase_t phase_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic exec_valid_q;
    logic flush_d;
    logic [STK_IDX_W-1:0] top_q;
    logic [STK_CNT_W-1:0] cnt_q;
    logic [PC_W-1:0] top_data;
    logic push_d, pop_d;
    logic irq_meta_q, irq_sync_q, irq_prev_q, irq_flag_q;
    logic pcl_pend_q;
    logic [7:0] pcl_data_q;
    logic boundary, take_int, stk_full, ack_d;

    assign boundary = (phase_q == PH_T4);
    assign stk_full = (cnt_q == STK_CNT_W'(LEVELS));
    // Interrupt only between ordinary instructions, never while full
    assign take_int = boundary && irq_flag_q && irq_en_i && !stk_full
        && exec_valid_q && (ctl_i.op == OP_NONE) && !pcl_pend_q;

    ////////////////////////////////////////////////////////////////////////
    // Phase generator

    // Free running INSTRUCTION_PHASE_CLOCKS, one lap is one instruction cycle
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            phase_q <= PH_T1;
        end
        else
        begin
            case (phase_q)
                PH_T1: phase_q <= PH_T2;
                PH_T2: phase_q <= PH_T3;
                PH_T3: phase_q <= PH_T4;
                PH_T4: phase_q <= PH_T1;
                default: phase_q <= PH_T1;
            endcase
        end
    end

    // One-hot phase strobes and fetch pulse for the core and memory
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            phase_o <= 4'h1;
            pm_fetch_o <= 1'b1;
        end
        else
        begin
            case (phase_q)
                PH_T1: phase_o <= 4'h2;
                PH_T2: phase_o <= 4'h4;
                PH_T3: phase_o <= 4'h8;
                PH_T4: phase_o <= 4'h1;
                default: phase_o <= 4'h1;
            endcase
            pm_fetch_o <= boundary;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next program counter at the cycle boundary

    // Priority: low byte write, interrupt, then the executing instruction
    always_comb
    begin
        pc_d = pc_inc(pc_q);
        flush_d = 1'b0;
        push_d = 1'b0;
        pop_d = 1'b0;
        ack_d = 1'b0;
        if (pcl_pend_q)
        begin
            pc_d = {pc_q[PC_W-1:8], pcl_data_q};
            flush_d = 1'b1;
        end
        else if (take_int)
        begin
            pc_d = INT_VECTOR;
            push_d = 1'b1;
            ack_d = 1'b1;
            flush_d = 1'b1;
        end
        else if (exec_valid_q)
        begin
            case (ctl_i.op)
                OP_JUMP:
                begin
                    pc_d = ctl_i.target;
                    flush_d = 1'b1;
                end
                OP_CALL:
                begin
                    pc_d = ctl_i.target;
                    push_d = 1'b1;
                    flush_d = 1'b1;
                end
                OP_SUB_RET, OP_INT_RET:
                begin
                    pc_d = top_data;
                    pop_d = 1'b1;
                    flush_d = 1'b1;
                end
                OP_SKIP: flush_d = 1'b1;
                default: flush_d = 1'b0;
            endcase
        end
    end

    // PC holds the fetch address; execution lags it by one cycle.
    // The memory address is a twin flop so the output comes from a register.
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pc_q <= PC_RESET;
            pm_addr_o <= PC_RESET;
        end
        else if (boundary)
        begin
            pc_q <= pc_d;
            pm_addr_o <= pc_d;
        end
    end

    // A flushed prefetch becomes a dummy cycle; first cycle after reset too
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            exec_valid_q <= 1'b0;
            exec_valid_o <= 1'b0;
            int_ack_o <= 1'b0;
            stack_full_o <= 1'b0;
        end
        else
        begin
            if (boundary)
            begin
                exec_valid_q <= !flush_d;
                exec_valid_o <= !flush_d;
            end
            int_ack_o <= ack_d;
            stack_full_o <= stk_full;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Return stack: ring of LEVELS entries, oldest lost on overflow

    // Pointer and fill count are internal only, no register reaches them
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            top_q <= STK_IDX_W'(LEVELS - 1);
            cnt_q <= '0;
        end
        else if (boundary && push_d)
        begin
            top_q <= idx_step(top_q, 1'b1);
            cnt_q <= stk_full ? cnt_q : cnt_q + 3'h1;
        end
        else if (boundary && pop_d)
        begin
            top_q <= idx_step(top_q, 1'b0);
            cnt_q <= (cnt_q == '0) ? cnt_q : cnt_q - 3'h1;
        end
    end

    // Read port always shows the top entry, ready well before T4
    pss_stack_mem #(
        .WIDTH(PC_W),
        .DEPTH(LEVELS),
        .AW(STK_IDX_W)
    ) u_stack (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .we_i(boundary && push_d),
        .waddr_i(idx_step(top_q, 1'b1)),
        .wdata_i(pc_q),
        .raddr_i(top_q),
        .rdata_o(top_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request flag

    // Pin level passes two flops before the edge detector looks at it
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            irq_meta_q <= 1'b0;
            irq_sync_q <= 1'b0;
            irq_prev_q <= 1'b0;
        end
        else
        begin
            irq_meta_q <= irq_i;
            irq_sync_q <= irq_meta_q;
            irq_prev_q <= irq_sync_q;
        end
    end

    // Flag is recorded even when full; a new edge wins over the ack clear
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            irq_flag_q <= 1'b0;
        else if (irq_sync_q && !irq_prev_q)
            irq_flag_q <= 1'b1;
        else if (ack_d)
            irq_flag_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port

    // Low byte write is held until the next boundary so it lands at T1
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pcl_pend_q <= 1'b0;
            pcl_data_q <= PC_LOW_RESET;
        end
        else if (reg_i.wr && reg_i.addr == OFS_PC_LOW)
        begin
            pcl_pend_q <= 1'b1;
            pcl_data_q <= reg_i.wdata;
        end
        else if (boundary)
        begin
            pcl_pend_q <= 1'b0;
        end
    end

    // Read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            reg_rdata_o <= '0;
        end
        else if (reg_i.rd && reg_i.addr == OFS_PC_LOW)
        begin
            reg_rdata_o <= pc_q[7:0];
        end
        else if (reg_i.rd && reg_i.addr == OFS_SEQ_STATUS)
        begin
            reg_rdata_o <= '0;
            reg_rdata_o[ST_FULL_BIT] <= stk_full;
            reg_rdata_o[ST_PEND_BIT] <= irq_flag_q;
            reg_rdata_o[ST_VALID_BIT] <= exec_valid_q;
        end
        else
        begin
            reg_rdata_o <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence seq_dummy_cycle;
        !exec_valid_q [*4];
    endsequence

    a_phase_order: assert property (phase_q == PH_T4 |=> phase_q == PH_T1)
        else $error("phase did not wrap to T1");
    a_fetch_rate: assert property (pm_fetch_o |=> !pm_fetch_o [*3] ##1 pm_fetch_o)
        else $error("fetch not once per four clocks");
    a_pc_step: assert property (boundary && !flush_d |=> pc_q == pc_inc($past(pc_q)))
        else $error("pc did not step by one");
    a_branch_dummy: assert property (boundary && exec_valid_q && !pcl_pend_q
        && ctl_i.op == OP_JUMP |=> seq_dummy_cycle ##0 pc_q == $past(ctl_i.target, 4))
        else $error("jump missing dummy cycle or target");
    a_skip_dummy: assert property (boundary && flush_d |=> seq_dummy_cycle)
        else $error("flush did not give a dummy cycle");
    a_call_push: assert property (boundary && push_d && !stk_full
        |=> cnt_q == $past(cnt_q) + 3'h1)
        else $error("push did not grow stack");
    a_ret_restore: assert property (boundary && pop_d |=> pc_q == $past(top_data))
        else $error("return did not restore pc");
    a_full_hold: assert property (stk_full && irq_flag_q |=> !int_ack_o)
        else $error("interrupt taken with full stack");
    a_pcl_page: assert property (boundary && pcl_pend_q
        |=> pc_q[10:8] == $past(pc_q[10:8]) && pc_q[7:0] == $past(pcl_data_q))
        else $error("low byte jump left the page");
endmodule // pss_sequencer
`default_nettype wire

// file: common/pss_pkg.sv
/*
 Shared constants and types of the program sequencer and return stack.
 Assumes one 50 MHz core clock and a core that reports control flow per cycle.
*/
package pss_pkg;
    // Clock and instruction cycle
    localparam int CLK_PERIOD_NS = 20;
    localparam int PHASES = 4;
    // Address space and stack shape
    localparam int PC_W = 11;
    localparam int PM_WORDS = 2048;
    localparam int STK_LEVELS = 6;
    localparam int STK_IDX_W = 3;
    localparam int STK_CNT_W = 3;
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    localparam logic [PC_W-1:0] INT_VECTOR = 11'h004;
    // Register port
    localparam int REG_AW = 8;
    localparam logic [REG_AW-1:0] OFS_PC_LOW = 8'h00;
    localparam logic [REG_AW-1:0] OFS_SEQ_STATUS = 8'h01;
    localparam logic [7:0] PC_LOW_RESET = 8'h00;
    // Status register field positions
    localparam int ST_CNT_LSB = 0;
    localparam int ST_FULL_BIT = 3;
    localparam int ST_PEND_BIT = 4;
    localparam int ST_VALID_BIT = 5;

    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} pss_phase_t;

    typedef enum logic [2:0] {
        OP_NONE, OP_JUMP, OP_CALL, OP_SUB_RET, OP_INT_RET, OP_SKIP
    } pss_op_t;

    // Control flow report of the executing instruction
    typedef struct packed {
        pss_op_t op;
        logic [PC_W-1:0] target;
    } pss_ctl_t;

    // Register port request
    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pss_reg_req_t;
endpackage

// file: design/pss_stack_mem.sv
/*
 Small register memory holding the return addresses.
 Assumes one writer and one reader, both on the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pss_stack_mem #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 6,
    parameter int AW = 3
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // Storage; no reset needed, the pointer guards the contents
    always_ff @(posedge core_clk_i)
    begin
        if (we_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Registered read port
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_o <= '0;
        end
        else
        begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule // pss_stack_mem
`default_nettype wire

// file: verification/pss_prog_mem_model.sv
/*
 Program memory model holding a fixed image of control-flow operations.
 Assumes the sequencer fetches during T1 and samples ctl at the end of T4.
*/
`timescale 1ns/1ns
`default_nettype none
module pss_prog_mem_model (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [pss_pkg::PC_W-1:0] pm_addr_i,
    input wire logic pm_fetch_i,
    input wire logic [3:0] phase_i,
    output var pss_pkg::pss_ctl_t ctl_o
);
    import pss_pkg::*;

    pss_ctl_t prog [PM_WORDS];
    pss_ctl_t fetched_q;

    ////////////////////////////////////////////////////////////////////////
    // Image: call, skip, return, then a seven-deep call chain that overflows
    initial
    begin
        for (int i = 0; i < PM_WORDS; i++)
        begin
            prog[i] = '{OP_NONE, 11'h000};
        end
        prog[11'h002] = '{OP_JUMP, 11'h010};
        prog[11'h004] = '{OP_INT_RET, 11'h000};
        prog[11'h010] = '{OP_CALL, 11'h100};
        prog[11'h012] = '{OP_JUMP, 11'h200};
        prog[11'h100] = '{OP_SKIP, 11'h000};
        prog[11'h102] = '{OP_SUB_RET, 11'h000};
        for (int n = 0; n < 7; n++)
        begin
            prog[11'h200 + 11'(16 * n)] = '{OP_CALL, 11'h210 + 11'(16 * n)};
        end
        for (int n = 2; n < 6; n++)
        begin
            prog[11'h201 + 11'(16 * n)] = '{OP_SUB_RET, 11'h000};
        end
        prog[11'h211] = '{OP_JUMP, 11'h300};
        prog[11'h262] = '{OP_SUB_RET, 11'h000};
        prog[11'h274] = '{OP_SUB_RET, 11'h000};
    end

    ////////////////////////////////////////////////////////////////////////
    // Word fetched in T1 is reported during the next instruction cycle
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            fetched_q <= '{OP_NONE, 11'h000};
            ctl_o <= '{OP_NONE, 11'h000};
        end
        else
        begin
            if (pm_fetch_i)
                fetched_q <= prog[pm_addr_i];
            if (phase_i == 4'h8)
                ctl_o <= fetched_q;
        end
    end
endmodule // pss_prog_mem_model
`default_nettype wire

// file: verification/program_sequencer_stack_test.sv
/*
 Self-checking bench of the program sequencer and return stack.
 Assumes the memory model image; irq enable is high until the last scenario.
*/
`timescale 1ns/1ns
`default_nettype none
module program_sequencer_stack_test;
    import pss_pkg::*;

    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic irq_i = 1'b0;
    logic irq_en_i = 1'b1;
    pss_ctl_t ctl;
    pss_reg_req_t reg_req = '0;
    logic [7:0] rdata;
    logic [PC_W-1:0] pm_addr;
    logic pm_fetch;
    logic [3:0] phase;
    logic ev;
    logic ack;
    logic full;
    logic [PC_W-1:0] last_pc;
    int fail_count = 0;
    int n_checks = 0;
    int ack_cnt = 0;

    initial
    begin
        forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
    end

    pss_sequencer DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ctl_i(ctl),
        .irq_i(irq_i), .irq_en_i(irq_en_i), .reg_i(reg_req), .reg_rdata_o(rdata),
        .pm_addr_o(pm_addr), .pm_fetch_o(pm_fetch), .phase_o(phase),
        .exec_valid_o(ev), .int_ack_o(ack), .stack_full_o(full));

    pss_prog_mem_model PM (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .pm_addr_i(pm_addr), .pm_fetch_i(pm_fetch), .phase_i(phase), .ctl_o(ctl));

    ////////////////////////////////////////////////////////////////////////
    // Verdict and shared compare
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Bounded waits; a stuck phase counter ends the run
    task automatic next_t1();
        for (int i = 0; i < 16; i++)
        begin
            @(posedge core_clk_i);
            #1;
            if (ack === 1'b1)
                ack_cnt++;
            if (phase === 4'h1)
                return;
        end
        fail_count++;
        wrap_up();
    endtask

    // Ordinary cycles must count up by one until the next dummy cycle
    task automatic wait_branch(input logic [PC_W-1:0] exp);
        for (int i = 0; i < 40; i++)
        begin
            next_t1();
            if (ev === 1'b0)
            begin
                chk(16'(pm_addr), 16'(exp));
                last_pc = exp;
                return;
            end
            chk(16'(pm_addr), 16'(last_pc + 11'h001));
            last_pc = pm_addr;
        end
        fail_count++;
        wrap_up();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Register port master
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk_i);
        reg_req <= '0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk_i);
        reg_req <= '0;
        #1;
        chk(16'(rdata), 16'(exp));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: two passes, the second after a mid-run reset
    initial
    begin
        repeat (20) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        for (int pass = 0; pass < 2; pass++)
        begin
            next_t1();
            chk(16'({pm_addr, ev}), 16'h0003);
            for (int k = 0; k < 4; k++)
            begin
                @(posedge core_clk_i);
                #1;
                chk(16'(phase), 16'(4'h1 << ((k + 1) % 4)));
                chk(16'(pm_fetch), 16'(k == 3));
            end
            last_pc = pm_addr;
            wait_branch(11'h010);
            wait_branch(11'h100);
            wait_branch(11'h102);
            wait_branch(11'h011);
            if (pass == 0)
            begin
                @(posedge core_clk_i);
                nrst_i <= 1'b0;
                @(posedge core_clk_i);
                #1;
                chk(16'({pm_addr, phase, full}), 16'h0002);
                repeat (20) @(posedge core_clk_i);
                nrst_i <= 1'b1;
            end
        end
        wait_branch(11'h200);
        for (int n = 1; n < 8; n++)
        begin
            wait_branch(11'h200 + 11'(16 * n));
        end
        chk(16'(full), 16'h0001);
        reg_read(OFS_SEQ_STATUS, 8'h08);
        @(posedge core_clk_i);
        irq_i <= 1'b1;
        wait_branch(11'h261);
        chk(16'(ack_cnt), 16'h0000);
        reg_read(OFS_SEQ_STATUS, 8'h10);
        chk(16'(full), 16'h0000);
        wait_branch(INT_VECTOR);
        chk(16'(ack_cnt), 16'h0001);
        @(posedge core_clk_i);
        irq_i <= 1'b0;
        wait_branch(11'h262);
        for (int n = 5; n > 0; n--)
        begin
            wait_branch(11'h201 + 11'(16 * n));
        end
        wait_branch(11'h300);
        reg_write(OFS_PC_LOW, 8'h45);
        wait_branch(11'h345);
        reg_read(OFS_PC_LOW, 8'h45);
        next_t1();
        reg_read(8'h07, 8'h00);
        next_t1();
        reg_write(OFS_SEQ_STATUS, 8'hff);
        next_t1();
        reg_read(OFS_SEQ_STATUS, 8'h20);
        // Masked request: flag is recorded but never acknowledged
        @(posedge core_clk_i);
        irq_en_i <= 1'b0;
        irq_i <= 1'b1;
        repeat (3) next_t1();
        chk(16'(ack_cnt), 16'h0001);
        reg_read(OFS_SEQ_STATUS, 8'h30);
        wrap_up();
    end
endmodule // program_sequencer_stack_test
`default_nettype wire
